// File: src/scp_top.v
// APB clock control: system clock prescaler and PLL control registers
// Function
// (RULE1) Unlock sets only on lone-bit write
// (RULE2) Unlock clears after four cycles or divide write
// (RULE3) Rewriting unlock neither restarts nor clears
// (RULE4) Divide field accepted only while unlocked
// (RULE5) Codes 0..8 divide by powers of two
// (RULE6) Reset divide from fuse: 0000 or 0011
// (RULE7) Any divide value writable after reset
// (RULE8) Software keeps system clock under maximum
// (RULE9) Software sets reference halve before enabling
// (RULE10) Setting run bit starts the PLL
// (RULE11) RC oscillator on when run and RC-source
// (RULE12) Software clears run before power-down
// (RULE13) Lock flag after lock time; run clear clears
// (RULE14) Reference source: prescaled primary or RC
// (RULE15) USB clock undivided or halved
// (RULE16) Timer postdivider: off, 1, 1.5, 2
// (RULE17) Divide by 1.5 keeps average exact
// (RULE18) Frequency field selects 40..96 MHz codes
// (RULE19) Reserved status bits read zero
// (RULE20) Software recommended 96 MHz setup
// (RULE21) Divide changes glitch-free, no faster step
// (RULE22) Software two-step unlock within four cycles
// (RULE23) Locked divide write keeps current setting
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.vh"
module scp_top #(
    parameter LOCK_CYCLES = `SCP_LOCK_TIME_US * `SCP_CLK_MHZ
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    // Fuse and clock controls
    input  wire        divide_by_eight_fuse,
    output reg         sysclk_en_ff,
    output reg  [3:0]  sysclk_div_ff,
    output reg         pll_run_ff,
    output reg         rc_osc_on_ff,
    output reg         pll_ref_halve_ff,
    output reg         pll_ref_source_sel_ff,
    output reg         pll_locked_flag_ff,
    output reg  [3:0]  vco_frequency_sel_ff,
    output reg         usb_clock_halve_ff,
    output reg         timer_clk_en_ff
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [3:0]  div_ff;
    reg         unlock_ff;
    reg  [2:0]  unlock_cnt_ff;
    reg         fuse_load_ff;
    reg  [7:0]  freq_ctl_ff;
    reg         ref_halve_ff;
    reg         run_ff;
    reg  [31:0] lock_cnt_ff;
    reg         locked_ff;
    reg  [8:0]  pre_cnt_ff;
    reg  [3:0]  eff_div_ff;
    reg  [3:0]  pend_div_ff;
    reg  [31:0] nxt_prdata;
    reg         nxt_slverr;
    wire        wr_acc;
    wire        rd_acc;
    wire        tmr_tick;
    wire [8:0]  eff_mask;

    // Power-of-two mask for a divide code; reserved codes clamp to 256
    function [8:0] scp_mask;
        input [3:0] code;
        begin
            if (code > `SCP_DIV_MAX)
                scp_mask = 9'h0FF;
            else
                scp_mask = (9'h001 << code) - 9'h001;              // RULE5
        end
    endfunction

    assign wr_acc   = psel & penable & pwrite & ~pready_ff;
    assign rd_acc   = psel & penable & ~pwrite & ~pready_ff;
    assign eff_mask = scp_mask(eff_div_ff);

    // ------------------------------------------------------------------------
    // APB answer: one wait state, ready pulses one cycle
    // ------------------------------------------------------------------------
    always @* begin
        nxt_prdata = 32'h00000000;
        nxt_slverr = 1'b0;
        if (paddr == `SCP_ADDR_CLKPRE) begin
            nxt_prdata = {24'h000000, unlock_ff, 3'h0, div_ff};
        end else if (paddr == `SCP_ADDR_PLLCS) begin
            nxt_prdata = {27'h0000000, ref_halve_ff, 2'h0,         // RULE19
                          run_ff, locked_ff};
        end else if (paddr == `SCP_ADDR_FREQ_CTL) begin
            nxt_prdata = {24'h000000, freq_ctl_ff};
        end else begin
            nxt_slverr = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & nxt_slverr;
            prdata_ff  <= rd_acc ? nxt_prdata : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler control and unlock window
    // ------------------------------------------------------------------------
    // Fuse is sampled by the first clock after release, never under reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_load_ff  <= 1'b1;
            div_ff        <= `SCP_DIV_RST_PLAIN;
            unlock_ff     <= 1'b0;
            unlock_cnt_ff <= 3'h0;
        end else begin
            fuse_load_ff <= 1'b0;
            if (fuse_load_ff) begin
                div_ff <= divide_by_eight_fuse ? `SCP_DIV_RST_FUSE  // RULE6
                                               : `SCP_DIV_RST_PLAIN;
            end
            if (wr_acc && paddr == `SCP_ADDR_CLKPRE && !fuse_load_ff) begin
                if (pwdata[7:0] == 8'h80) begin
                    if (!unlock_ff) begin                          // RULE3
                        unlock_ff     <= 1'b1;                     // RULE1
                        unlock_cnt_ff <= `SCP_UNLOCK_CYCLES;
                    end else begin
                        unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
                        if (unlock_cnt_ff == 3'h1)
                            unlock_ff <= 1'b0;
                    end
                end else if (unlock_ff && !pwdata[`SCP_UNLOCK_BIT]) begin
                    div_ff        <= pwdata[3:0];                  // RULE4 RULE7
                    unlock_ff     <= 1'b0;                         // RULE2
                    unlock_cnt_ff <= 3'h0;
                end else if (unlock_ff) begin
                    unlock_cnt_ff <= unlock_cnt_ff - 3'h1;         // RULE23
                    if (unlock_cnt_ff == 3'h1)
                        unlock_ff <= 1'b0;
                end
            end else if (unlock_ff) begin
                unlock_cnt_ff <= unlock_cnt_ff - 3'h1;             // RULE2
                if (unlock_cnt_ff == 3'h1)
                    unlock_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Glitch-free system clock enable
    // ------------------------------------------------------------------------
    // New ratio is taken only at a period boundary, so no short period appears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_ff   <= 9'h000;
            eff_div_ff   <= `SCP_DIV_RST_PLAIN;
            pend_div_ff  <= `SCP_DIV_RST_PLAIN;
            sysclk_en_ff <= 1'b0;
        end else begin
            pend_div_ff <= div_ff;
            if ((pre_cnt_ff & eff_mask) == eff_mask) begin
                pre_cnt_ff   <= 9'h000;
                eff_div_ff   <= pend_div_ff;                       // RULE21
                sysclk_en_ff <= 1'b1;
            end else begin
                pre_cnt_ff   <= pre_cnt_ff + 9'h001;
                sysclk_en_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // PLL control, frequency register and lock timer
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_ctl_ff  <= `SCP_FREQ_CTL_RST;
            ref_halve_ff <= 1'b0;
            run_ff       <= 1'b0;
        end else if (wr_acc && paddr == `SCP_ADDR_PLLCS) begin
            ref_halve_ff <= pwdata[`SCP_REFHALVE_BIT];
            run_ff       <= pwdata[`SCP_RUN_BIT];                  // RULE10
        end else if (wr_acc && paddr == `SCP_ADDR_FREQ_CTL) begin
            freq_ctl_ff  <= pwdata[7:0];                           // RULE18
        end
    end

    // Lock timer models the loop settling; time is a parameter for simulation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_ff <= 32'h00000000;
            locked_ff   <= 1'b0;
        end else if (!run_ff) begin
            lock_cnt_ff <= 32'h00000000;
            locked_ff   <= 1'b0;                                   // RULE13
        end else if (lock_cnt_ff >= LOCK_CYCLES - 1) begin
            locked_ff   <= 1'b1;                                   // RULE13
        end else begin
            lock_cnt_ff <= lock_cnt_ff + 32'h00000001;
        end
    end

    // Timer clock enable from the postdivider
    scp_postdiv u_postdiv (
        .pclk    (pclk),
        .presetn (presetn),
        .mode    (freq_ctl_ff[`SCP_TMR_HI:`SCP_TMR_LO]),
        .tick_ff (tmr_tick)
    );

    // Registered copies drive the clock control outputs other than sysclk_en_ff
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_div_ff         <= 4'h0;
            pll_run_ff            <= 1'b0;
            rc_osc_on_ff          <= 1'b0;
            pll_ref_halve_ff      <= 1'b0;
            pll_ref_source_sel_ff <= 1'b0;
            pll_locked_flag_ff    <= 1'b0;
            vco_frequency_sel_ff  <= 4'h4;
            usb_clock_halve_ff    <= 1'b0;
            timer_clk_en_ff       <= 1'b0;
        end else begin
            sysclk_div_ff         <= eff_div_ff;
            pll_run_ff            <= run_ff;
            rc_osc_on_ff          <= run_ff & freq_ctl_ff[`SCP_REFSEL_BIT]; // RULE11
            pll_ref_halve_ff      <= ref_halve_ff;
            pll_ref_source_sel_ff <= freq_ctl_ff[`SCP_REFSEL_BIT]; // RULE14
            pll_locked_flag_ff    <= locked_ff;
            vco_frequency_sel_ff  <= freq_ctl_ff[3:0];
            usb_clock_halve_ff    <= freq_ctl_ff[`SCP_USBHALVE_BIT]; // RULE15
            timer_clk_en_ff       <= tmr_tick;                     // RULE16
        end
    end
endmodule // scp_top
`default_nettype wire

// File: src/scp_consts.vh
// Constants for the system clock prescaler and PLL control block
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define SCP_IDX_FREQ_CTL    8'h32
`define SCP_ADDR_FREQ_CTL   12'h0C8
`define SCP_ADDR_CLKPRE     12'h000
`define SCP_ADDR_PLLCS      12'h004

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCP_UNLOCK_BIT      7
`define SCP_REFHALVE_BIT    4
`define SCP_RUN_BIT         1
`define SCP_LOCK_BIT        0
`define SCP_REFSEL_BIT      7
`define SCP_USBHALVE_BIT    6
`define SCP_TMR_HI          5
`define SCP_TMR_LO          4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define SCP_FREQ_CTL_RST    8'h04
`define SCP_DIV_RST_FUSE    4'h3
`define SCP_DIV_RST_PLAIN   4'h0
`define SCP_DIV_MAX         4'h8
`define SCP_UNLOCK_CYCLES   3'h4
`define SCP_LOCK_TIME_US    2000
`define SCP_CLK_MHZ         250

`endif

// File: src/scp_postdiv.v
// Timer clock postdivider: off, /1, /1.5, /2 enables on pclk
`timescale 1ns/10ps
`default_nettype none
module scp_postdiv (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire [1:0] mode,
    // Output
    output reg        tick_ff
);
    reg  [1:0] phase_ff;
    reg  [1:0] nxt_phase;
    reg        nxt_tick;

    // Enable pattern; /1.5 gives two ticks per three cycles, so average is exact
    always @* begin
        nxt_phase = 2'h0;
        nxt_tick  = 1'b0;
        case (mode)
            2'h1: nxt_tick = 1'b1;                                 // RULE16
            2'h2: begin                                            // RULE17
                nxt_phase = (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
                nxt_tick  = (phase_ff != 2'h2);
            end
            2'h3: begin
                nxt_phase = {1'b0, ~phase_ff[0]};
                nxt_tick  = phase_ff[0];
            end
            default: nxt_tick = 1'b0;                              // RULE16
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 2'h0;
            tick_ff  <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            tick_ff  <= nxt_tick;
        end
    end
endmodule // scp_postdiv
`default_nettype wire

// File: tb/scp_top_asserts.sv
// Port-level checks for the clock control block
`timescale 1ns/10ps
`default_nettype none
module scp_asserts #(
    parameter LOCK_CYCLES = 20
) (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata_ff,
    input wire logic        pready_ff,
    input wire logic        pslverr_ff,
    // Clock controls
    input wire logic        sysclk_en_ff,
    input wire logic [3:0]  sysclk_div_ff,
    input wire logic        pll_run_ff,
    input wire logic        rc_osc_on_ff,
    input wire logic        pll_ref_source_sel_ff,
    input wire logic        pll_locked_flag_ff
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // History of divide writes and run time
    // ------------------------------------------------------------
    logic [9:0]  since_wr_ff;
    logic [31:0] run_cnt_ff;
    // A new ratio waits up to one old period (256 cycles) plus pipeline stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_wr_ff  <= 10'h0;
            run_cnt_ff   <= 32'h0;
        end else begin
            since_wr_ff  <= (psel & penable & pwrite & ~pready_ff & (paddr == 12'h000)) ?
                            10'h0 : since_wr_ff + {9'h0, since_wr_ff != 10'h3FF};
            run_cnt_ff   <= pll_run_ff ? run_cnt_ff + 32'h1 : 32'h0;
        end
    end
    sequence access_s;
        psel && penable && !pready_ff;
    endsequence
    sequence run_off_s;
        !pll_run_ff ##1 !pll_run_ff;
    endsequence
    ready_after_access_a: assert property (access_s |=> pready_ff)
        else $error("no ready one cycle after access");
    ready_pulse_a: assert property (pready_ff |=> !pready_ff)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr_ff |-> pready_ff)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready_ff |-> prdata_ff == 32'h0)
        else $error("read data outside ready cycle");
    div_guarded_a: assert property (
        !$stable(sysclk_div_ff) |-> since_wr_ff < 10'd300)
        else $error("divide changed without a write");
    en_rate_a: assert property (
        sysclk_en_ff && sysclk_div_ff != 4'h0 && $stable(sysclk_div_ff)
        ##1 $stable(sysclk_div_ff) |-> !sysclk_en_ff)
        else $error("system enable faster than divide");
    rc_follow_a: assert property (
        rc_osc_on_ff == (pll_run_ff && pll_ref_source_sel_ff))
        else $error("rc oscillator enable wrong");
    lock_time_a: assert property (
        $rose(pll_locked_flag_ff) |-> pll_run_ff && run_cnt_ff >= LOCK_CYCLES - 1
        && run_cnt_ff <= LOCK_CYCLES + 2)
        else $error("lock flag at wrong time");
    lock_drop_a: assert property (run_off_s |-> !pll_locked_flag_ff)
        else $error("lock flag kept without run");
endmodule // scp_asserts
bind scp_top scp_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_scp_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .sysclk_en_ff(sysclk_en_ff), .sysclk_div_ff(sysclk_div_ff),
    .pll_run_ff(pll_run_ff), .rc_osc_on_ff(rc_osc_on_ff),
    .pll_ref_source_sel_ff(pll_ref_source_sel_ff), .pll_locked_flag_ff(pll_locked_flag_ff)
);
`default_nettype wire

// File: tb/sysclk_prescaler_and_pll_control_tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.vh"
module sysclk_prescaler_and_pll_control_tb;
    localparam int LOCK_N = 20;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        divide_by_eight_fuse = 1'b1;
    wire  [31:0] prdata_ff;
    wire  [3:0]  sysclk_div_ff, vco_frequency_sel_ff;
    wire         pready_ff, pslverr_ff, sysclk_en_ff, pll_run_ff, rc_osc_on_ff;
    wire         pll_ref_halve_ff, pll_ref_source_sel_ff, pll_locked_flag_ff;
    wire         usb_clock_halve_ff, timer_clk_en_ff;
    int          failures = 0;
    int          check_count = 0;
    logic [15:0] lfsr_q = 16'h5F1E;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  v;
    scp_top #(.LOCK_CYCLES(LOCK_N)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .divide_by_eight_fuse(divide_by_eight_fuse), .sysclk_en_ff(sysclk_en_ff),
        .sysclk_div_ff(sysclk_div_ff), .pll_run_ff(pll_run_ff), .rc_osc_on_ff(rc_osc_on_ff),
        .pll_ref_halve_ff(pll_ref_halve_ff), .pll_ref_source_sel_ff(pll_ref_source_sel_ff),
        .pll_locked_flag_ff(pll_locked_flag_ff), .vco_frequency_sel_ff(vco_frequency_sel_ff),
        .usb_clock_halve_ff(usb_clock_halve_ff), .timer_clk_en_ff(timer_clk_en_ff)
    );
    // 250 MHz clock
    always #2 pclk = ~pclk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Ticks in twelve cycles for each timer postdivider mode
    function automatic int tick_exp(input logic [1:0] m);
        return (m == 2'h0) ? 0 : (m == 2'h1) ? 12 : (m == 2'h2) ? 8 : 6;
    endfunction
    task automatic test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Called just after an edge; leaves the bus held so transfers chain
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready_ff !== 1'b1 && k < 50);
        rd = prdata_ff;
        err = pslverr_ff;
        if (k >= 50)
            chk(32'h1, 32'h0);
    endtask
    task automatic idle(input int c);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (c) @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Count enable pulses once the divide change has settled
    task automatic rate(input logic [3:0] c);
        int k;
        k = 0;
        repeat (800) @(posedge pclk);
        repeat (512) begin
            @(posedge pclk);
            k += int'(sysclk_en_ff === 1'b1);
        end
        chk(k, 32'h200 >> c);
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #160000;
        failures++;
        test_done();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`SCP_ADDR_CLKPRE, 32'h3);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h05);
        rdchk(`SCP_ADDR_CLKPRE, 32'h3);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h81);
        rdchk(`SCP_ADDR_CLKPRE, 32'h3);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h80);
        rdchk(`SCP_ADDR_CLKPRE, 32'h83);
        idle(6);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h05);
        rdchk(`SCP_ADDR_CLKPRE, 32'h3);
        // A rewrite must not stretch the unlock window
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h80);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h80);
        apb(1'b1, `SCP_ADDR_CLKPRE, 32'h06);
        rdchk(`SCP_ADDR_CLKPRE, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        rdchk(`SCP_ADDR_FREQ_CTL, {24'h0, `SCP_FREQ_CTL_RST});
        apb(1'b1, `SCP_ADDR_PLLCS, 32'h10);
        apb(1'b1, `SCP_ADDR_PLLCS, 32'hFF);
        rdchk(`SCP_ADDR_PLLCS, 32'h12);
        idle(1);
        chk({pll_run_ff, pll_ref_halve_ff, pll_locked_flag_ff}, 32'h6);
        idle(LOCK_N + 4);
        rdchk(`SCP_ADDR_PLLCS, 32'h13);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v = {lfsr_q[7:6], i[1:0], lfsr_q[3:0]};
            apb(1'b1, `SCP_ADDR_FREQ_CTL, {24'h0, v});
            rdchk(`SCP_ADDR_FREQ_CTL, {24'h0, v});
            idle(3);
            chk({pll_ref_source_sel_ff, usb_clock_halve_ff, vco_frequency_sel_ff}, {v[7:6], v[3:0]});
            chk(rc_osc_on_ff, v[7]);
            rate_ticks(v[5:4]);
        end
        // Recommended setup: 96 MHz, timer /1.5, USB /2
        apb(1'b1, `SCP_ADDR_FREQ_CTL, 32'h6A);
        idle(3);
        chk({usb_clock_halve_ff, vco_frequency_sel_ff}, 32'h1A);
        rate_ticks(2'h2);
        apb(1'b1, `SCP_ADDR_PLLCS, 32'h0);
        idle(3);
        chk({pll_locked_flag_ff, rc_osc_on_ff}, 32'h0);
        // Second reset in mid-run with the fuse unprogrammed
        divide_by_eight_fuse <= 1'b0;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`SCP_ADDR_CLKPRE, 32'h0);
        for (int c = 0; c < 9; c++) begin
            apb(1'b1, `SCP_ADDR_CLKPRE, 32'h80);
            apb(1'b1, `SCP_ADDR_CLKPRE, c);
            rdchk(`SCP_ADDR_CLKPRE, c);
            idle(1);
            rate(c[3:0]);
            chk(sysclk_div_ff, c);
        end
        test_done();
    end
    // Timer tick count over twelve settled cycles
    task automatic rate_ticks(input logic [1:0] m);
        int k;
        k = 0;
        repeat (12) begin
            @(posedge pclk);
            k += int'(timer_clk_en_ff === 1'b1);
        end
        chk(k, tick_exp(m));
    endtask
endmodule // sysclk_prescaler_and_pll_control_tb
`default_nettype wire
